//--- src/cssp_regs.vh
// register offsets, field positions, reset values and timing for the clocked serial shift port
`ifndef CSSP_REGS_VH
`define CSSP_REGS_VH
// register offsets (4-bit address space)
`define CSSP_ADDR_MODE      4'h0
`define CSSP_ADDR_PORTA     4'h1
`define CSSP_ADDR_PORTC     4'h2
`define CSSP_ADDR_DATA      4'h3
`define CSSP_ADDR_STATUS    4'h4
`define CSSP_ADDR_CMD       4'h5
// port control A: transfer mode select in bits 1:0
`define CSSP_XFER_RECV      2'h2
`define CSSP_XFER_BOTH      2'h3
`define CSSP_XFER_CLKOUT    2'h0
// serial mode register: clock source select in bits 3:0
`define CSSP_CLK_EXTERNAL   4'hF
// port control C bits
`define CSSP_PC_DIV4_BIT    0
`define CSSP_PC_IDLE_BIT    1
// status bits
`define CSSP_ST_DONE_BIT    0
// command bits
`define CSSP_CMD_START_BIT  0
// reset values
`define CSSP_MODE_RESET     4'h0
`define CSSP_PORTA_RESET    2'h0
`define CSSP_PORTC_RESET    2'h0
// internal transfer clock timing: system clocks per prescaler tick
`define CSSP_PRESCALE_DIV   8'h04
`endif

//--- src/cssp_shift_port.v
// clocked serial shift port: 8-bit synchronous shifter with state machine and register port
//
// Overview of operation
// - mode field 10 selects receive only
// - mode field 11 selects transmit and receive
// - mode field 00 with internal clock gives continuous clock only
// - clock source 1111 selects external clock
// - mode register write reinitialises, start wait
// - start instruction enters clock wait state
// - first falling clock edge enters transfer
// - shift right, input at MSB, out LSB
// - eight clocks clear counter, set done flag
// - external clock: byte end returns to clock wait
// - internal clock: byte end stops, start wait
// - mode write mid-transfer aborts and sets flag
// - idle level write drives output immediately
// - after transfer output holds transmitted MSB
// - idle level ignored on output during transfer
// - internal mode drives clock pin output
// - divide select picks prescale by 2 or 4
// - continuous clock runs until mode write
// - eighth pulse ends byte, next edge restarts
// - leaving transfer via mode write sets flag
// - done flag cleared only by software zero
`timescale 1ns/1ps
`include "cssp_regs.vh"

module cssp_shift_port (
    // clock and reset
    input  wire       sys_clk,
    input  wire       nrst,
    // register port
    input  wire [3:0] regAddr,
    input  wire [7:0] regWdata,
    input  wire       regWrite,
    input  wire       regRead,
    output reg  [7:0] regRdata,
    // serial clock pin, active low, two-way
    input  wire       serClkIn,
    output reg        serClkOut,
    output reg        serClkOe,
    // serial data pins
    input  wire       serDataIn,
    output reg        serDataOut,
    output reg        serDataOe
);

    // port states
    localparam [1:0] ST_START_WAIT = 2'h0;
    localparam [1:0] ST_CLOCK_WAIT = 2'h1;
    localparam [1:0] ST_TRANSFER   = 2'h2;
    localparam [1:0] ST_CONT_CLOCK = 2'h3;

    // control registers
    reg [3:0] serialModeReg;
    reg [1:0] transferModeReg;
    reg       idleLevelReg;
    reg       divideSelReg;
    reg [7:0] shiftReg;
    reg [2:0] bitCountReg;
    reg       doneFlagReg;
    reg [1:0] stateReg;
    // pin synchronisers
    reg       clkSync1Reg;
    reg       clkSync2Reg;
    reg       clkPrevReg;
    reg       dinSync1Reg;
    reg       dinSync2Reg;
    // internal clock generation
    reg [7:0] prescaleReg;
    reg [1:0] divPhaseReg;
    reg       intClkReg;

    // decoded strobes
    wire modeWrite  = regWrite && (regAddr == `CSSP_ADDR_MODE);
    wire portAWrite = regWrite && (regAddr == `CSSP_ADDR_PORTA);
    wire portCWrite = regWrite && (regAddr == `CSSP_ADDR_PORTC);
    wire dataWrite  = regWrite && (regAddr == `CSSP_ADDR_DATA);
    wire statWrite  = regWrite && (regAddr == `CSSP_ADDR_STATUS);
    wire startCmd   = regWrite && (regAddr == `CSSP_ADDR_CMD)
                      && regWdata[`CSSP_CMD_START_BIT];
    wire extClock   = (serialModeReg == `CSSP_CLK_EXTERNAL);
    wire transmitOn = transferModeReg[0];
    wire receiveOn  = transferModeReg[1];

    // internal clock is high during its first half, so an edge train starts with a fall
    wire prescaleTick = (prescaleReg == (`CSSP_PRESCALE_DIV - 8'h01));
    wire divEnd       = divideSelReg ? (divPhaseReg == 2'h1) : (divPhaseReg == 2'h0);
    wire intRunning   = (stateReg == ST_TRANSFER) || (stateReg == ST_CONT_CLOCK)
                        || (stateReg == ST_CLOCK_WAIT);
    wire intToggle    = !extClock && intRunning && prescaleTick && divEnd;
    wire intFall      = intToggle && intClkReg;
    wire intRise      = intToggle && !intClkReg;

    // selected clock edges
    wire extFall  = clkPrevReg && !clkSync2Reg;
    wire extRise  = !clkPrevReg && clkSync2Reg;
    wire clkFall  = extClock ? extFall : intFall;
    wire clkRise  = extClock ? extRise : intRise;
    // the eighth falling edge wraps the counter to zero, so its rising edge ends the byte
    wire byteDone = (stateReg == ST_TRANSFER) && clkRise && (bitCountReg == 3'h0);

    // pin synchronisers: first stage feeds only the second
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            clkSync1Reg <= 1'b1;
            clkSync2Reg <= 1'b1;
            clkPrevReg  <= 1'b1;
            dinSync1Reg <= 1'b0;
            dinSync2Reg <= 1'b0;
        end
        else
        begin
            clkSync1Reg <= serClkIn;
            clkSync2Reg <= clkSync1Reg;
            clkPrevReg  <= clkSync2Reg;
            dinSync1Reg <= serDataIn;
            dinSync2Reg <= dinSync1Reg;
        end
    end

    // prescaler and divide-by-2/4 stage; restarts whenever the clock is stopped
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prescaleReg <= 8'h00;
            divPhaseReg <= 2'h0;
            intClkReg   <= 1'b1;
        end
        else if (!intRunning || modeWrite)
        begin
            prescaleReg <= 8'h00;
            divPhaseReg <= 2'h0;
            intClkReg   <= 1'b1;
        end
        else if (prescaleTick)
        begin
            prescaleReg <= 8'h00;
            divPhaseReg <= divEnd ? 2'h0 : divPhaseReg + 2'h1;
            if (intToggle)
                intClkReg <= !intClkReg;
        end
        else
        begin
            prescaleReg <= prescaleReg + 8'h01;
        end
    end

    // configuration registers
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            serialModeReg   <= `CSSP_MODE_RESET;
            transferModeReg <= `CSSP_PORTA_RESET;
            idleLevelReg    <= 1'b0;
            divideSelReg    <= 1'b0;
        end
        else
        begin
            if (modeWrite)
                serialModeReg <= regWdata[3:0];
            if (portAWrite)
                transferModeReg <= regWdata[1:0];
            if (portCWrite)
            begin
                idleLevelReg <= regWdata[`CSSP_PC_IDLE_BIT];
                divideSelReg <= regWdata[`CSSP_PC_DIV4_BIT];
            end
        end
    end

    // port state machine, bit counter and done flag
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stateReg    <= ST_START_WAIT;
            bitCountReg <= 3'h0;
            doneFlagReg <= 1'b0;
        end
        else
        begin
            // software clear first, so a same-cycle hardware set wins
            if (statWrite && !regWdata[`CSSP_ST_DONE_BIT])
                doneFlagReg <= 1'b0;
            if (modeWrite)
            begin
                // mode write reinitialises from any state
                stateReg    <= ST_START_WAIT;
                bitCountReg <= 3'h0;
                if (stateReg == ST_TRANSFER)
                    doneFlagReg <= 1'b1;
            end
            else
            begin
                case (stateReg)
                    ST_START_WAIT:
                    begin
                        if (startCmd)
                            stateReg <= ST_CLOCK_WAIT;
                    end
                    ST_CLOCK_WAIT:
                    begin
                        if (clkFall)
                        begin
                            if (!extClock && transferModeReg == `CSSP_XFER_CLKOUT)
                                stateReg <= ST_CONT_CLOCK;
                            else
                            begin
                                stateReg    <= ST_TRANSFER;
                                bitCountReg <= 3'h1;
                            end
                        end
                    end
                    ST_TRANSFER:
                    begin
                        if (startCmd)
                        begin
                            stateReg    <= ST_CLOCK_WAIT;
                            bitCountReg <= 3'h0;
                            doneFlagReg <= 1'b1;
                        end
                        else if (byteDone)
                        begin
                            bitCountReg <= 3'h0;
                            doneFlagReg <= 1'b1;
                            stateReg    <= extClock ? ST_CLOCK_WAIT
                                                    : ST_START_WAIT;
                        end
                        else if (clkFall)
                            bitCountReg <= bitCountReg + 3'h1;
                    end
                    ST_CONT_CLOCK:
                    begin
                        stateReg <= ST_CONT_CLOCK;
                    end
                    default:
                    begin
                        stateReg <= ST_START_WAIT;
                    end
                endcase
            end
        end
    end

    // shift register: loaded by software, shifts right on rising clock edges
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            shiftReg <= 8'h00;
        else if (dataWrite && stateReg != ST_TRANSFER)
            shiftReg <= regWdata;
        else if (stateReg == ST_TRANSFER && clkRise)
            shiftReg <= {receiveOn ? dinSync2Reg : shiftReg[0], shiftReg[7:1]};
    end

    // serial data output: idle level, or lsb while shifting out
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            serDataOut <= 1'b0;
            serDataOe  <= 1'b0;
        end
        else
        begin
            serDataOe <= transmitOn;
            if (stateReg == ST_TRANSFER)
            begin
                // in transfer the idle level write has no effect on the pin
                if (transmitOn && clkFall)
                    serDataOut <= shiftReg[0];
            end
            else if (portCWrite)
                serDataOut <= regWdata[`CSSP_PC_IDLE_BIT];
            else if (stateReg == ST_CLOCK_WAIT && transmitOn && clkFall)
                serDataOut <= shiftReg[0];
            // otherwise the last driven bit, the byte's MSB, stays put
        end
    end

    // clock pin: driven only with the internal source
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            serClkOut <= 1'b1;
            serClkOe  <= 1'b0;
        end
        else
        begin
            serClkOe  <= !extClock;
            serClkOut <= intClkReg;
        end
    end

    // register read data, one cycle after the strobe
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            regRdata <= 8'h00;
        else if (regRead)
        begin
            case (regAddr)
                `CSSP_ADDR_MODE:   regRdata <= {4'h0, serialModeReg};
                `CSSP_ADDR_PORTA:  regRdata <= {6'h00, transferModeReg};
                `CSSP_ADDR_PORTC:  regRdata <= {6'h00, idleLevelReg, divideSelReg};
                `CSSP_ADDR_DATA:   regRdata <= shiftReg;
                `CSSP_ADDR_STATUS: regRdata <= {2'b00, bitCountReg, stateReg, doneFlagReg};
                default:           regRdata <= 8'h00;
            endcase
        end
        else
            regRdata <= 8'h00;
    end

endmodule

//--- test/cssp_far_end.sv
// far-end serial device: makes the external clock, feeds and captures data
`timescale 1ns/1ps
module cssp_far_end (
    // clock pin level and the clock this end makes
    input  wire  pinClk,
    output logic extClk,
    // data lines
    output logic sdi,
    input  wire  sdo
);
    logic [7:0] txReg, rxReg;
    int         bitCnt;
    initial
    begin
        extClk = 1'b1;
        sdi = 1'b0;
        txReg = 8'h00;
        rxReg = 8'h00;
        bitCnt = 0;
    end
    // new bit on the falling edge so it is settled at the sampling edge
    always @(negedge pinClk)
        sdi <= txReg[bitCnt % 8];
    // capture on rising edge; after a byte the line stops showing data
    always @(posedge pinClk)
    begin
        rxReg <= {sdo, rxReg[7:1]};
        bitCnt <= bitCnt + 1;
        // release only after the port has sampled the last bit
        if (bitCnt % 8 == 7)
            sdi <= #20 ~sdi;
    end
    task load(input logic [7:0] b);
        txReg = b;
        bitCnt = 0;
    endtask
    // off the system edges, halves of 8 system cycles
    task pulses(input int n);
        #2;
        repeat (n)
        begin
            extClk = 1'b0;
            #80;
            extClk = 1'b1;
            #80;
        end
    endtask
endmodule

//--- test/cssp_shift_port_assertions.sv
// checker for the clocked serial shift port pins
`timescale 1ns/1ps
module cssp_shift_port_assertions (
    // clock and reset
    input wire       sys_clk,
    input wire       nrst,
    // register port
    input wire [3:0] regAddr,
    input wire [7:0] regWdata,
    input wire       regWrite,
    input wire       regRead,
    input wire [7:0] regRdata,
    // serial pins
    input wire       serClkIn,
    input wire       serClkOut,
    input wire       serClkOe,
    input wire       serDataIn,
    input wire       serDataOut,
    input wire       serDataOe
);
    reg [3:0] halfCnt_reg;
    reg       lastClk_reg;
    reg       rdStat_reg;
    reg       doneSeen_reg;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // clock pin age saturates, so a stopped clock reads as long ago
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            halfCnt_reg  <= 4'h0;
            lastClk_reg  <= 1'b1;
            rdStat_reg   <= 1'b0;
            doneSeen_reg <= 1'b0;
        end
        else
        begin
            lastClk_reg  <= serClkOut;
            halfCnt_reg  <= (serClkOut != lastClk_reg) ? 4'h0 : halfCnt_reg + {3'h0, halfCnt_reg != 4'hF};
            rdStat_reg   <= regRead && regAddr == 4'h4;
            doneSeen_reg <= (regWrite && regAddr == 4'h4) ? 1'b0 : doneSeen_reg | (rdStat_reg & regRdata[0]);
        end
    end
    clk_oe_a: assert property (regWrite && regAddr == 4'h0
        |-> ##2 serClkOe == (($past(regWdata, 2) & 8'h0F) != 8'h0F)) else $error("clock enable wrong");
    data_oe_a: assert property (regWrite && regAddr == 4'h1
        |-> ##2 serDataOe == (($past(regWdata, 2) & 8'h01) != 8'h00)) else $error("data enable wrong");
    idle_level_a: assert property (regWrite && regAddr == 4'h2
        |-> ##2 serDataOut == (($past(regWdata, 2) & 8'h02) != 8'h00)) else $error("idle level wrong");
    clk_stop_a: assert property (regWrite && regAddr == 4'h0
        |-> ##2 serClkOut [*8]) else $error("clock not stopped");
    half_period_a: assert property ($fell(serClkOut)
        |-> halfCnt_reg == 4'h3 || halfCnt_reg == 4'h7 || halfCnt_reg > 4'h9) else $error("bad half");
    ext_quiet_a: assert property (!serClkOe && !$past(serClkOe) && !$past(serClkOe, 2)
        |-> $stable(serClkOut)) else $error("clock moves while not driven");
    mode_init_a: assert property (regWrite && regAddr == 4'h0 ##1 regRead && regAddr == 4'h4
        |=> (regRdata & 8'h3E) == 8'h00) else $error("mode write did not reinitialise");
    done_keep_a: assert property (rdStat_reg && doneSeen_reg
        |-> regRdata[0]) else $error("done flag lost");
endmodule
bind cssp_shift_port cssp_shift_port_assertions chk (.sys_clk(sys_clk), .nrst(nrst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .serClkIn(serClkIn), .serClkOut(serClkOut), .serClkOe(serClkOe),
    .serDataIn(serDataIn), .serDataOut(serDataOut), .serDataOe(serDataOe));

//--- test/test_cssp_shift_port.sv
// self-checking bench for the clocked serial shift port
`timescale 1ns/1ps
module test_cssp_shift_port;
    logic        sys_clk, nrst, regWrite, regRead;
    logic [3:0]  regAddr;
    logic [7:0]  regWdata, v, tx, rx;
    logic [31:0] seed;
    wire  [7:0]  regRdata;
    wire         serClkOut, serClkOe, serDataOut, serDataOe, extClk, sdi, pinClk;
    int          error_cnt, compares, i, n;
    // whichever end enables the clock pin drives it
    assign pinClk = serClkOe ? serClkOut : extClk;
    cssp_shift_port dut (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .serClkIn(pinClk),
        .serClkOut(serClkOut), .serClkOe(serClkOe), .serDataIn(sdi), .serDataOut(serDataOut),
        .serDataOe(serDataOe));
    cssp_far_end far (.pinClk(pinClk), .extClk(extClk), .sdi(sdi), .sdo(serDataOut));
    always #5 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // expected status: count, state, done
    function automatic logic [7:0] st(input int c, input int s, input int d);
        return 8'(c * 8 + s * 2 + d);
    endfunction
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // the write strobe stays up between back-to-back writes; idle or a read lowers it
    task wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regRead <= 1'b0;
        regWrite <= 1'b1;
        @(posedge sys_clk);
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        regAddr <= a;
        regWrite <= 1'b0;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
        @(posedge sys_clk);
    endtask
    task idle(input int k);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        repeat (k) @(posedge sys_clk);
    endtask
    task start;
        idle(4);
        wr(4'h5, 8'h01);
        idle(1);
    endtask
    task conclude;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        sys_clk = 0;
        nrst = 0;
        regAddr = 0;
        regWdata = 0;
        regWrite = 0;
        regRead = 0;
        error_cnt = 0;
        compares = 0;
        seed = 48;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rd(4'h4, v);
        chk(v, st(0, 0, 0));
        // external clock, both directions, idle level high
        wr(4'h1, 8'h03);
        wr(4'h0, 8'h0F);
        wr(4'h2, 8'h02);
        idle(3);
        chk({6'h00, serDataOut, serDataOe}, 8'h03);
        for (i = 0; i < 3; i++)
        begin
            seed = xs(seed);
            tx = seed[7:0];
            seed = xs(seed);
            rx = seed[7:0];
            wr(4'h4, 8'h00);
            wr(4'h3, tx);
            if (i == 0)
                start();
            rd(4'h4, v);
            chk(v, st(0, 1, 0));
            far.load(rx);
            idle(1);
            far.pulses(8);
            idle(6);
            rd(4'h4, v);
            chk(v, st(0, 1, 1));
            rd(4'h3, v);
            chk(v, rx);
            chk(far.rxReg, tx);
            chk({7'h00, serDataOut}, {7'h00, tx[7]});
        end
        // noise: eighth pulse ends the byte, the rest begin another
        wr(4'h4, 8'h00);
        far.load(8'h00);
        idle(1);
        far.pulses(11);
        idle(6);
        rd(4'h4, v);
        chk(v, st(3, 2, 1));
        wr(4'h4, 8'h00);
        wr(4'h0, 8'h0F);
        rd(4'h4, v);
        chk(v, st(0, 0, 1));
        // internal clock receive at both prescale divisions
        for (i = 0; i < 2; i++)
        begin
            seed = xs(seed);
            rx = seed[7:0];
            wr(4'h1, 8'h02);
            wr(4'h0, 8'h00);
            wr(4'h2, 8'(i));
            wr(4'h4, 8'h00);
            far.load(rx);
            start();
            n = 0;
            v = 0;
            while (v[0] !== 1'b1 && n < 200)
            begin
                rd(4'h4, v);
                n++;
            end
            chk(v, st(0, 0, 1));
            if (n >= 200)
                conclude();
            rd(4'h3, v);
            chk(v, rx);
            chk({6'h00, serDataOe, serClkOe}, 8'h01);
        end
        // continuous clock until a mode write
        wr(4'h4, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h00);
        start();
        idle(40);
        rd(4'h4, v);
        chk(v, st(0, 3, 0));
        wr(4'h0, 8'h00);
        rd(4'h4, v);
        chk(v, st(0, 0, 0));
        conclude();
    end
endmodule
